// *** fro_map.svh ***
`ifndef FRO_MAP_SVH
`define FRO_MAP_SVH

// register addresses
`define FRO_ADDR_STATUS     8'h0b
`define FRO_ADDR_FILTER     8'h2c
`define FRO_ADDR_POWER      8'h2d
`define FRO_ADDR_MAP_A      8'h2a
`define FRO_ADDR_MAP_B      8'h2b
`define FRO_ADDR_DATA_LO_A  8'h08
`define FRO_ADDR_DATA_LO_B  8'h0a
`define FRO_ADDR_DATA_HI_A  8'h0e
`define FRO_ADDR_DATA_HI_B  8'h15

// event_status bit positions
`define FRO_ST_DRDY         0
`define FRO_ST_FIFO_RDY     1
`define FRO_ST_WM           2
`define FRO_ST_OVR          3
`define FRO_ST_MOTION       4
`define FRO_ST_STILL        5
`define FRO_SRC_W           6

// control bit positions
`define FRO_MAP_POL_BIT     7
`define FRO_FILT_TRIG_BIT   3
`define FRO_PWR_CLK_BIT     6

// reset values
`define FRO_RST_MAP         8'h00
`define FRO_RST_FILTER      8'h00
`define FRO_RST_POWER       8'h00
`define FRO_EMPTY_BYTE      8'h00

// buffer geometry
`define FRO_FIFO_W          16
`define FRO_FIFO_D          16
`define FRO_LVL_W           5

`endif

// *** fro_pkg.sv ***
package fro_pkg;

    typedef struct packed {
        logic [1:0]  tag;
        logic [1:0]  sext;
        logic [11:0] data;
    } fro_word_t;

    typedef struct packed {
        logic [11:0] x;
        logic [11:0] y;
        logic [11:0] z;
        logic [11:0] temp;
    } fro_set_t;

    typedef struct packed {
        logic       oe;
        logic       o;
    } fro_pin_drv_t;

    // low two bits of the busy states are the entry's source tag
    typedef enum logic [2:0] {
        FRO_WR_X    = 3'b000,
        FRO_WR_Y    = 3'b001,
        FRO_WR_Z    = 3'b010,
        FRO_WR_T    = 3'b011,
        FRO_WR_IDLE = 3'b100
    } fro_wr_state_t;

endpackage

// *** fro_top.sv ***
// Overview of operation
// - each entry leaves as two bytes, low byte first, then high byte
// - bits 11:0 hold the sample, bits 13:12 copy its sign bit
// - bits 15:14 tag the source: 00 x, 01 y, 10 z, 11 temperature
// - bytes read beyond an empty buffer return zero
// - each set is stored x, y, z, then temperature if enabled
// - entries that do not fit are dropped, leaving a partial set
// - space is freed one entry at a time as each entry is read
// - each source routes to either pin; a pin ORs its routed sources
// - a pin with nothing routed, and both pins at reset, float
// - pins are active high unless the route map polarity bit is set
// - reading event_status clears motion and stillness flags
// - reading a sample data register clears the data ready flag
// - buffer ready, watermark, overrun clear once reads remove the cause
// - outside clock select turns pin a into a clock input
// - outside trigger select turns pin b into a sample trigger input
// - a pin in its input role never drives an event level
// - status bit 4 flags motion, bit 5 flags stillness
// - status bit 0 is set while new sample data is waiting
// - new data during a data read sets the flag only after the read
// - a data read clears the flag at its start and holds it clear
// - status bit 2 is set while stored count reaches the threshold
// - status bit 1 is set while an entry waits at the output
// - status bit 3 flags lost data; cleared by a read or disable
`timescale 1ns/100ps
`default_nettype none
`include "fro_map.svh"

module fro_sync
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic pin_i,
    output logic      level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // a change counts once the second and third stages agree
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                level <= s3_r;
        end
    end
endmodule

module fro_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
)
(
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire logic                       flush,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH):0]          level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign level     = cnt_r;

    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    always_ff @(posedge mclk)
    begin
        if (rst || flush)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module fro_top
    import fro_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic [7:0]           reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_wdata,
    output logic [7:0]                reg_rdata,
    input  wire logic                 fifo_byte_rd,
    input  wire logic                 data_rd_busy,
    input  wire logic                 fifo_en,
    input  wire logic                 temp_store_en,
    input  wire logic [`FRO_LVL_W-1:0] wm_level,
    input  wire logic                 sample_valid,
    input  wire fro_set_t             sample_set,
    input  wire logic                 motion_event,
    input  wire logic                 stillness_event,
    input  wire logic                 irq_pin_a_i,
    output logic                      irq_pin_a_o,
    output logic                      irq_pin_a_oe,
    input  wire logic                 irq_pin_b_i,
    output logic                      irq_pin_b_o,
    output logic                      irq_pin_b_oe,
    output logic                      outside_clock_tick,
    output logic                      sample_trigger,
    output logic [7:0]                filter_setup,
    output logic [7:0]                power_setup
);
    fro_wr_state_t   wr_state_r;
    fro_wr_state_t   wr_state_nxt;
    fro_set_t        set_r;
    logic            set_temp_r;
    logic [7:0]      pin_a_route_map;
    logic [7:0]      pin_b_route_map;
    logic            drdy_r;
    logic            drdy_pend_r;
    logic            hold_d_r;
    logic            motion_flag;
    logic            stillness_flag;
    logic            ovr_r;
    logic            fifo_rdy_r;
    logic            wm_r;
    logic            hi_phase_r;
    logic            had_word_r;
    logic            clk_lvl_d_r;
    logic            trg_lvl_d_r;
    logic            clk_lvl;
    logic            trg_lvl;
    logic            fifo_in_ready;
    logic            fifo_out_valid;
    logic [15:0]     fifo_out_data;
    logic [`FRO_LVL_W-1:0] fifo_level;
    fro_word_t       entry;
    fro_pin_drv_t    drv_a_nxt;
    fro_pin_drv_t    drv_b_nxt;

    wire wr_busy   = !wr_state_r[2];
    wire entry_sel_hi = wr_state_r[1];
    wire [11:0] cur_sample = entry_sel_hi
        ? (wr_state_r[0] ? set_r.temp : set_r.z)
        : (wr_state_r[0] ? set_r.y    : set_r.x);
    assign entry.tag  = wr_state_r[1:0];
    assign entry.sext = {2{cur_sample[11]}};
    assign entry.data = cur_sample;

    wire drop_entry = wr_busy && !fifo_in_ready;
    wire lo_read    = fifo_byte_rd && !hi_phase_r;
    wire hi_read    = fifo_byte_rd && hi_phase_r;
    wire fifo_pop   = hi_read && had_word_r;

    wire status_rd  = reg_rd && (reg_addr == `FRO_ADDR_STATUS);
    wire data_reg_rd = reg_rd &&
        (((reg_addr >= `FRO_ADDR_DATA_LO_A) &&
          (reg_addr <= `FRO_ADDR_DATA_LO_B)) ||
         ((reg_addr >= `FRO_ADDR_DATA_HI_A) &&
          (reg_addr <= `FRO_ADDR_DATA_HI_B)));
    wire data_hold  = data_rd_busy || data_reg_rd;
    wire hold_end   = hold_d_r && !data_hold;

    wire [`FRO_SRC_W-1:0] src = {stillness_flag, motion_flag, ovr_r,
                                 wm_r, fifo_rdy_r, drdy_r};
    wire [7:0] status_byte = {2'b00, src};
    wire clk_alt = power_setup[`FRO_PWR_CLK_BIT];
    wire trg_alt = filter_setup[`FRO_FILT_TRIG_BIT];
    wire clk_rise = clk_alt && clk_lvl && !clk_lvl_d_r;
    wire trg_rise = trg_alt && trg_lvl && !trg_lvl_d_r;
    wire map_a_any = |pin_a_route_map[`FRO_SRC_W-1:0];
    wire map_b_any = |pin_b_route_map[`FRO_SRC_W-1:0];
    wire act_a = |(src & pin_a_route_map[`FRO_SRC_W-1:0]);
    wire act_b = |(src & pin_b_route_map[`FRO_SRC_W-1:0]);

    wire pol_a = pin_a_route_map[`FRO_MAP_POL_BIT];
    wire pol_b = pin_b_route_map[`FRO_MAP_POL_BIT];
    assign drv_a_nxt.o  = act_a ^ pol_a;
    assign drv_b_nxt.o  = act_b ^ pol_b;
    assign drv_a_nxt.oe = map_a_any && !clk_alt;
    assign drv_b_nxt.oe = map_b_any && !trg_alt;

    wire [7:0] fifo_byte = hi_phase_r
        ? (had_word_r ? fifo_out_data[15:8] : `FRO_EMPTY_BYTE)
        : (fifo_out_valid ? fifo_out_data[7:0] : `FRO_EMPTY_BYTE);
    wire [7:0] reg_byte =
        (reg_addr == `FRO_ADDR_STATUS) ? status_byte :
        (reg_addr == `FRO_ADDR_FILTER) ? filter_setup :
        (reg_addr == `FRO_ADDR_POWER)  ? power_setup :
        (reg_addr == `FRO_ADDR_MAP_A)  ? pin_a_route_map :
        (reg_addr == `FRO_ADDR_MAP_B)  ? pin_b_route_map : 8'h00;

    fro_fifo #(
        .WIDTH (`FRO_FIFO_W),
        .DEPTH (`FRO_FIFO_D)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .flush     (!fifo_en),
        .in_valid  (wr_busy),
        .in_ready  (fifo_in_ready),
        .in_data   (entry),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    fro_sync u_sync_a (
        .mclk  (mclk),
        .rst   (rst),
        .pin_i (irq_pin_a_i),
        .level (clk_lvl)
    );

    fro_sync u_sync_b (
        .mclk  (mclk),
        .rst   (rst),
        .pin_i (irq_pin_b_i),
        .level (trg_lvl)
    );

    // one entry per cycle; a set is never interrupted by the next
    always_comb
    begin
        wr_state_nxt = wr_state_r;
        unique case (wr_state_r)
            FRO_WR_IDLE:
                if (sample_valid && fifo_en)
                    wr_state_nxt = FRO_WR_X;
            FRO_WR_X:
                wr_state_nxt = FRO_WR_Y;
            FRO_WR_Y:
                wr_state_nxt = FRO_WR_Z;
            FRO_WR_Z:
                wr_state_nxt = set_temp_r ? FRO_WR_T : FRO_WR_IDLE;
            FRO_WR_T:
                wr_state_nxt = FRO_WR_IDLE;
            default:
                wr_state_nxt = FRO_WR_IDLE;
        endcase
        if (!fifo_en)
            wr_state_nxt = FRO_WR_IDLE;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wr_state_r <= FRO_WR_IDLE;
            set_r      <= '0;
            set_temp_r <= 1'b0;
        end
        else
        begin
            wr_state_r <= wr_state_nxt;
            if (!wr_busy && sample_valid)
            begin
                set_r      <= sample_set;
                set_temp_r <= temp_store_en;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            filter_setup    <= `FRO_RST_FILTER;
            power_setup     <= `FRO_RST_POWER;
            pin_a_route_map <= `FRO_RST_MAP;
            pin_b_route_map <= `FRO_RST_MAP;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `FRO_ADDR_FILTER)
                filter_setup <= reg_wdata;
            if (reg_addr == `FRO_ADDR_POWER)
                power_setup <= reg_wdata;
            if (reg_addr == `FRO_ADDR_MAP_A)
                pin_a_route_map <= reg_wdata;
            if (reg_addr == `FRO_ADDR_MAP_B)
                pin_b_route_map <= reg_wdata;
        end
    end

    // byte readout: low byte first, entry popped on its high byte
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            reg_rdata  <= 8'h00;
            hi_phase_r <= 1'b0;
            had_word_r <= 1'b0;
        end
        else
        begin
            if (fifo_byte_rd)
                reg_rdata <= fifo_byte;
            else if (reg_rd)
                reg_rdata <= reg_byte;
            if (!fifo_en)
            begin
                hi_phase_r <= 1'b0;
                had_word_r <= 1'b0;
            end
            else if (lo_read)
            begin
                hi_phase_r <= 1'b1;
                had_word_r <= fifo_out_valid;
            end
            else if (hi_read)
                hi_phase_r <= 1'b0;
        end
    end

    // event flags; a setting event wins over a clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            motion_flag    <= 1'b0;
            stillness_flag <= 1'b0;
            ovr_r          <= 1'b0;
            fifo_rdy_r     <= 1'b0;
            wm_r           <= 1'b0;
        end
        else
        begin
            if (motion_event)
                motion_flag <= 1'b1;
            else if (status_rd)
                motion_flag <= 1'b0;
            if (stillness_event)
                stillness_flag <= 1'b1;
            else if (status_rd)
                stillness_flag <= 1'b0;
            if (drop_entry)
                ovr_r <= 1'b1;
            else if (fifo_pop || !fifo_en)
                ovr_r <= 1'b0;
            fifo_rdy_r <= fifo_out_valid;
            wm_r       <= (fifo_level >= wm_level);
        end
    end

    // data ready is held clear for the whole data read
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            drdy_r      <= 1'b0;
            drdy_pend_r <= 1'b0;
            hold_d_r    <= 1'b0;
        end
        else
        begin
            hold_d_r <= data_hold;
            if (data_hold)
            begin
                drdy_r <= 1'b0;
                if (sample_valid)
                    drdy_pend_r <= 1'b1;
            end
            else if (hold_end)
            begin
                drdy_r      <= drdy_pend_r || sample_valid;
                drdy_pend_r <= 1'b0;
            end
            else if (sample_valid)
                drdy_r <= 1'b1;
        end
    end

    // pins and alternate inputs
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq_pin_a_o        <= 1'b0;
            irq_pin_a_oe       <= 1'b0;
            irq_pin_b_o        <= 1'b0;
            irq_pin_b_oe       <= 1'b0;
            clk_lvl_d_r        <= 1'b0;
            trg_lvl_d_r        <= 1'b0;
            outside_clock_tick <= 1'b0;
            sample_trigger     <= 1'b0;
        end
        else
        begin
            irq_pin_a_o  <= drv_a_nxt.o;
            irq_pin_a_oe <= drv_a_nxt.oe;
            irq_pin_b_o  <= drv_b_nxt.o;
            irq_pin_b_oe <= drv_b_nxt.oe;
            clk_lvl_d_r  <= clk_lvl;
            trg_lvl_d_r  <= trg_lvl;
            outside_clock_tick <= clk_rise;
            sample_trigger <= trg_rise;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_pop_on_high;
        fifo_pop |-> hi_phase_r && fifo_byte_rd &&
            $past(hi_phase_r || lo_read);
    endproperty
    a_pop_on_high: assert property (p_pop_on_high)
        else $error("entry popped outside a high byte read");

    property p_empty_zero;
        (lo_read && !fifo_out_valid) || (hi_read && !had_word_r)
            |=> reg_rdata == 8'h00;
    endproperty
    a_empty_zero: assert property (p_empty_zero)
        else $error("read past empty buffer returned nonzero");

    property p_entry_format;
        wr_busy |-> entry.tag == wr_state_r[1:0] &&
            entry.sext == {2{entry.data[11]}};
    endproperty
    a_entry_format: assert property (p_entry_format)
        else $error("buffer entry tag or sign copy wrong");

    property p_set_order;
        (wr_state_r == FRO_WR_X) && fifo_en |=> wr_state_r == FRO_WR_Y
            ##1 (wr_state_r == FRO_WR_Z || !fifo_en);
    endproperty
    a_set_order: assert property (p_set_order)
        else $error("sample set entries out of order");

    property p_unmapped_float;
        !map_a_any |=> !irq_pin_a_oe;
    endproperty
    a_unmapped_float: assert property (p_unmapped_float)
        else $error("pin a driven with nothing routed");

    property p_pin_level;
        ##1 irq_pin_a_o == ($past(act_a) ^
            $past(pin_a_route_map[`FRO_MAP_POL_BIT]));
    endproperty
    a_pin_level: assert property (p_pin_level)
        else $error("pin a level does not follow routed flags");

    property p_alt_no_drive;
        clk_alt |=> !irq_pin_a_oe;
    endproperty
    a_alt_no_drive: assert property (p_alt_no_drive)
        else $error("pin a driven while used as clock input");

    property p_status_clear;
        status_rd && !motion_event |=> !motion_flag;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("motion flag survived status read");

    property p_drdy_hold;
        data_hold |=> !drdy_r;
    endproperty
    a_drdy_hold: assert property (p_drdy_hold)
        else $error("data ready set during a data read");

    property p_wm;
        ##1 wm_r == ($past(fifo_level) >= $past(wm_level));
    endproperty
    a_wm: assert property (p_wm)
        else $error("watermark flag disagrees with level");

    property p_ovr;
        drop_entry |=> ovr_r;
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("dropped entry without overrun flag");

    c_temp_set: cover property (wr_state_r == FRO_WR_T);
    c_empty_read: cover property (lo_read && !fifo_out_valid);
    c_pin_a_on: cover property (irq_pin_a_oe && irq_pin_a_o);
    c_partial: cover property (drop_entry);
endmodule

`default_nettype wire

// *** fro_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module fro_host
(
    input  wire logic a_o,
    input  wire logic a_oe,
    input  wire logic b_o,
    input  wire logic b_oe,
    input  wire logic clk_on,
    input  wire logic trg_on,
    input  wire logic trg,
    output logic      pin_a,
    output logic      pin_b
);
    logic xclk   = 1'h0;
    logic keep_a = 1'h0;
    logic keep_b = 1'h0;
    // outside clock stands still while switched off
    always #400 xclk = clk_on ? ~xclk : 1'h0;
    // undriven pins hold their last level on the bus keepers
    assign pin_a = a_oe ? a_o : (clk_on ? xclk : keep_a);
    assign pin_b = b_oe ? b_o : (trg_on ? trg : keep_b);
    always @(pin_a) keep_a = pin_a;
    always @(pin_b) keep_b = pin_b;
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "fro_map.svh"
module tb_top
    import fro_pkg::*;
;
    logic                  mclk = 1'h0, rst = 1'h1;
    logic [7:0]            reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
    logic                  reg_wr = 1'h0, reg_rd = 1'h0, fifo_byte_rd = 1'h0;
    logic                  data_rd_busy = 1'h0, fifo_en = 1'h1;
    logic                  temp_store_en = 1'h1, sample_valid = 1'h0;
    logic                  motion_event = 1'h0, stillness_event = 1'h0;
    logic [`FRO_LVL_W-1:0] wm_level = 5'h04;
    fro_set_t              sample_set = '0;
    logic                  clk_on = 1'h0, trg_on = 1'h0, trg = 1'h0;
    logic                  pin_a, pin_b, a_o, a_oe, b_o, b_oe, tick, strig;
    logic [7:0]            filt, pwr;
    logic [11:0]           base [3] = '{12'h100, 12'hf00, 12'h0a0};
    int                    n_errors = 0, compares = 0, cyc = 0;
    int                    nticks = 0, ntrig = 0;

    fro_top fro_top_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(rdata), .fifo_byte_rd(fifo_byte_rd),
        .data_rd_busy(data_rd_busy), .fifo_en(fifo_en),
        .temp_store_en(temp_store_en), .wm_level(wm_level),
        .sample_valid(sample_valid), .sample_set(sample_set),
        .motion_event(motion_event), .stillness_event(stillness_event),
        .irq_pin_a_i(pin_a), .irq_pin_a_o(a_o), .irq_pin_a_oe(a_oe),
        .irq_pin_b_i(pin_b), .irq_pin_b_o(b_o), .irq_pin_b_oe(b_oe),
        .outside_clock_tick(tick), .sample_trigger(strig),
        .filter_setup(filt), .power_setup(pwr));
    fro_host fro_host_inst (.a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe),
        .clk_on(clk_on), .trg_on(trg_on), .trg(trg), .pin_a(pin_a),
        .pin_b(pin_b));

    always #50 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc++;
        nticks += int'(tick === 1'h1);
        ntrig += int'(strig === 1'h1);
        if (cyc == 5000)
        begin
            n_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(negedge mclk);
        reg_wr = 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'h1;
        @(negedge mclk);
        reg_rd = 1'h0;
        chk8(rdata, e);
    endtask

    task automatic fb(input logic [7:0] e);
        @(negedge mclk);
        fifo_byte_rd = 1'h1;
        @(negedge mclk);
        fifo_byte_rd = 1'h0;
        chk8(rdata, e);
    endtask

    // whole entries only, low byte then high byte
    task automatic rw(input logic [15:0] e);
        fb(e[7:0]);
        fb(e[15:8]);
    endtask

    task automatic push(input logic [47:0] s);
        @(negedge mclk);
        sample_set = s;
        sample_valid = 1'h1;
        @(negedge mclk);
        sample_valid = 1'h0;
        repeat (5) @(negedge mclk);
    endtask

    task automatic pulse(input logic m, input logic [3:0] e);
        @(negedge mclk);
        motion_event = m;
        stillness_event = ~m;
        @(negedge mclk);
        motion_event = 1'h0;
        stillness_event = 1'h0;
        @(negedge mclk);
        chk8({4'h0, a_oe, a_o, b_oe, b_o}, {4'h0, e});
    endtask

    function automatic logic [15:0] wd(input logic [1:0] t,
                                       input logic [11:0] d);
        return {t, {2{d[11]}}, d};
    endfunction

    initial
    begin
        repeat (2) @(negedge mclk);
        rst = 1'h0;
        chk8({4'h0, a_oe, a_o, b_oe, b_o}, 8'h00);
        data_rd_busy = 1'h1;
        push({12'h800, 12'h7ff, 12'h123, 12'habc});
        rd(`FRO_ADDR_STATUS, 8'h06);
        data_rd_busy = 1'h0;
        rd(`FRO_ADDR_STATUS, 8'h07);
        rw(wd(2'h0, 12'h800));
        rw(wd(2'h1, 12'h7ff));
        rw(wd(2'h2, 12'h123));
        rw(wd(2'h3, 12'habc));
        rw(16'h0000);
        rd(`FRO_ADDR_STATUS, 8'h01);
        data_rd_busy = 1'h1;
        rd(`FRO_ADDR_STATUS, 8'h00);
        data_rd_busy = 1'h0;
        rd(`FRO_ADDR_STATUS, 8'h00);
        $display("test format done");
        temp_store_en = 1'h0;
        for (int s = 0; s < 6; s++)
            push({base[0] + 12'(s), base[1] + 12'(s),
                  base[2] + 12'(s), 12'h000});
        rd(`FRO_ADDR_STATUS, 8'h0f);
        for (int k = 0; k < 16; k++)
        begin
            rw(wd(2'(k % 3), base[k % 3] + 12'(k / 3)));
            if (k == 0)
                rd(`FRO_ADDR_STATUS, 8'h07);
        end
        rw(16'h0000);
        rd(`FRO_ADDR_STATUS, 8'h01);
        rd(`FRO_ADDR_DATA_LO_A, 8'h00);
        rd(`FRO_ADDR_STATUS, 8'h00);
        $display("test overrun done");
        // maps are set while no event is pending
        wr(`FRO_ADDR_STATUS, 8'hff);
        rd(`FRO_ADDR_STATUS, 8'h00);
        wr(`FRO_ADDR_MAP_A, 8'h10);
        wr(`FRO_ADDR_MAP_B, 8'ha0);
        pulse(1'h1, 4'hf);
        pulse(1'h0, 4'he);
        rd(`FRO_ADDR_STATUS, 8'h30);
        @(negedge mclk);
        chk8({4'h0, a_oe, a_o, b_oe, b_o}, 8'h0b);
        wr(`FRO_ADDR_MAP_A, 8'h00);
        wr(`FRO_ADDR_MAP_B, 8'h00);
        @(negedge mclk);
        chk8({4'h0, a_oe, a_o, b_oe, b_o}, 8'h00);
        $display("test pins done");
        wr(`FRO_ADDR_POWER, 8'h40);
        wr(`FRO_ADDR_FILTER, 8'h08);
        wr(`FRO_ADDR_MAP_A, 8'h10);
        wr(`FRO_ADDR_MAP_B, 8'h10);
        // both pins float; the levels behind them still follow the flags
        pulse(1'h1, 4'h5);
        chk8(pwr, 8'h40);
        chk8(filt, 8'h08);
        rd(`FRO_ADDR_POWER, 8'h40);
        clk_on = 1'h1;
        repeat (80) @(negedge mclk);
        clk_on = 1'h0;
        trg_on = 1'h1;
        repeat (10) @(negedge mclk);
        trg = 1'h1;
        repeat (5) @(negedge mclk);
        trg = 1'h0;
        repeat (10) @(negedge mclk);
        chk8(8'(nticks >= 9 && nticks <= 11), 8'h01);
        chk8(8'(ntrig), 8'h01);
        $display("test alternate done");
        close_out();
    end
endmodule
`default_nettype wire
